// >>> hdl/mal_lookup.sv
// MAC address lookup: static and learned tables, indirect access, counters.
// Assumes lookup requesters hold request and key until their done pulse.
`timescale 1ns/1ps
module mal_lookup import mal_pkg::*; #(
    parameter int MIB_N = 32
) (
    input logic ref_clk,
    input logic rst,
    input logic [2:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input logic vlan_en,
    input logic da_req,
    input logic [47:0] da_mac,
    input logic [3:0] da_grp,
    input logic [1:0] da_port,
    output logic da_done,
    output logic da_hit,
    output logic da_static,
    output logic [2:0] da_fwd,
    output logic da_override,
    input logic sa_req,
    input logic [47:0] sa_mac,
    input logic [3:0] sa_grp,
    input logic [1:0] sa_port,
    output logic sa_done,
    output logic sa_hit,
    output logic sa_moved,
    input logic age_tick,
    input logic [2*MIB_N-1:0] mib_inc,
    input logic [3:0] drop_inc
);
    // ==========================================================
    // State
    typedef struct packed {
        mal_st_t st;
        logic [9:0] addr;
        logic [NDYN-1:0] dv;
        logic [10:0] cnt;
        logic [9:0] age_ix;
        logic age_on;
        logic hr_pend;
        logic [9:0] hr_ix;
        logic [15:0] iac;
        logic [NSTAT-1:0][57:0] stat;
        logic [71:0] dat;
        logic [2*MIB_N-1:0][30:0] mib;
        logic [4:0][15:0] drop;
        logic st_hit;
        logic [2:0] st_fwd;
        logic st_ovr;
        logic wrq;
        logic [31:0] rdata;
        logic da_done;
        logic da_hit;
        logic da_stat;
        logic [2:0] da_fwd;
        logic da_ovr;
        logic sa_done;
        logic sa_hit;
        logic sa_mov;
    } mal_state_t;

    mal_state_t s_r;
    mal_state_t s_nxt;
    logic [55:0] dmem [NDYN];
    logic [55:0] rd_q;
    logic mem_we;
    logic [9:0] mem_wa;
    logic [55:0] mem_wd;
    logic acc;
    logic wcmt;
    logic pp_rd;
    int pp_j;

    // ==========================================================
    // Helpers
    function automatic logic [9:0] mal_hash(input logic [47:0] m, input logic [3:0] f, input logic ven);
        mal_hash = m[9:0] ^ m[19:10] ^ m[29:20] ^ {6'h0, ven ? f : 4'h0};
    endfunction : mal_hash

    function automatic logic [2:0] mal_pbit(input logic [1:0] p);
        mal_pbit = 3'(3'h1 << p);
    endfunction : mal_pbit

    function automatic logic [15:0] mal_be16(input logic [15:0] o, input logic [15:0] w, input logic [1:0] be);
        mal_be16 = {be[1] ? w[15:8] : o[15:8], be[0] ? w[7:0] : o[7:0]};
    endfunction : mal_be16

    function automatic logic mal_dmatch(input logic [55:0] e, input logic [47:0] m, input logic [3:0] f,
                                        input logic ven);
        mal_dmatch = (e[47:0] == m) && (!ven || e[DF_GRP_LO+:4] == f);
    endfunction : mal_dmatch

    assign acc = (avs_read || avs_write) && s_r.wrq;
    assign wcmt = avs_write && !s_r.wrq;

    // ==========================================================
    // Next state
    always_comb begin
        logic [15:0] iw;
        logic [9:0] ix;
        logic [9:0] dx;
        logic [55:0] e;
        logic dm;
        logic [30:0] t;
        logic [1:0] ts;
        iw = '0;
        ix = '0;
        dx = '0;
        e = '0;
        dm = 1'b0;
        t = '0;
        ts = '0;
        s_nxt = s_r;
        mem_we = 1'b0;
        mem_wa = s_r.addr;
        mem_wd = rd_q;
        pp_rd = 1'b0;
        pp_j = 0;
        s_nxt.da_done = 1'b0;
        s_nxt.sa_done = 1'b0;
        s_nxt.wrq = WRQ_RST;
        if (age_tick && !s_r.age_on) begin
            s_nxt.age_on = 1'b1;
            s_nxt.age_ix = '0;
        end
        // Host reads first so a polling host is never starved
        // A requester sees done one edge late, so a request standing beside done is not taken again
        unique case (s_r.st)
            S_IDLE: begin
                if (s_r.hr_pend) begin
                    s_nxt.addr = s_r.hr_ix;
                    s_nxt.st = S_HR;
                end else if (da_req && !s_r.da_done) begin
                    s_nxt.addr = mal_hash(da_mac, da_grp, vlan_en);
                    s_nxt.st = S_DA;
                    s_nxt.st_hit = 1'b0;
                    s_nxt.st_fwd = '0;
                    s_nxt.st_ovr = 1'b0;
                    for (int k = NSTAT - 1; k >= 0; k--) begin
                        if (s_r.stat[k][SF_VAL] && s_r.stat[k][47:0] == da_mac &&
                            (!s_r.stat[k][SF_USEGRP] || s_r.stat[k][GRP_HI:GRP_LO] == da_grp)) begin
                            s_nxt.st_hit = 1'b1;
                            s_nxt.st_fwd = s_r.stat[k][SF_FWD_LO+:3];
                            s_nxt.st_ovr = s_r.stat[k][SF_OVR];
                        end
                    end
                end else if (sa_req && !s_r.sa_done) begin
                    s_nxt.addr = mal_hash(sa_mac, sa_grp, vlan_en);
                    s_nxt.st = S_SA;
                end else if (s_r.age_on) begin
                    s_nxt.addr = s_r.age_ix;
                    s_nxt.st = S_AG;
                end
            end
            S_DA: begin
                dm = s_r.dv[s_r.addr] && mal_dmatch(rd_q, da_mac, da_grp, vlan_en);
                s_nxt.da_done = 1'b1;
                s_nxt.st = S_IDLE;
                s_nxt.da_hit = s_r.st_hit || dm;
                s_nxt.da_stat = s_r.st_hit;
                if (s_r.st_hit) begin
                    s_nxt.da_fwd = (s_r.st_fwd == 3'h7) ? (s_r.st_fwd & ~mal_pbit(da_port)) : s_r.st_fwd;
                    s_nxt.da_ovr = s_r.st_ovr;
                end else begin
                    s_nxt.da_fwd = dm ? mal_pbit(rd_q[DF_PORT_LO+:2]) : 3'h0;
                    s_nxt.da_ovr = 1'b0;
                end
            end
            S_SA: begin
                dm = s_r.dv[s_r.addr] && mal_dmatch(rd_q, sa_mac, sa_grp, vlan_en);
                s_nxt.sa_done = 1'b1;
                s_nxt.sa_hit = dm;
                s_nxt.sa_mov = dm && rd_q[DF_PORT_LO+:2] != sa_port;
                s_nxt.st = S_IDLE;
                mem_we = 1'b1;
                mem_wd = {TS_FRESH, sa_port, sa_grp, sa_mac};
                if (!s_r.dv[s_r.addr]) begin
                    s_nxt.dv[s_r.addr] = 1'b1;
                    s_nxt.cnt = s_r.cnt + 11'h1;
                end
            end
            S_AG: begin
                ts = rd_q[DF_TS_LO+:2];
                if (s_r.dv[s_r.addr]) begin
                    if (ts == 2'h0) begin
                        s_nxt.dv[s_r.addr] = 1'b0;
                        s_nxt.cnt = s_r.cnt - 11'h1;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd[DF_TS_LO+:2] = ts - 2'h1;
                    end
                end
                s_nxt.age_ix = s_r.age_ix + 10'h1;
                s_nxt.age_on = s_r.age_ix != 10'(NDYN - 1);
                s_nxt.st = S_IDLE;
            end
            S_HR: begin
                if (s_r.hr_pend && s_r.addr == s_r.hr_ix) begin
                    e = s_r.dv[s_r.addr] ? rd_q : 56'h0;
                    s_nxt.dat = {5'h00, s_r.cnt == 11'h0,
                                 s_r.cnt == 11'h0 ? 10'h000 : 10'(s_r.cnt - 11'h1), e};
                    s_nxt.hr_pend = 1'b0;
                end
                s_nxt.st = S_IDLE;
            end
        endcase
        // ======================================================
        // Bus slave: one-cycle answer, then waitrequest rises again
        if (acc) begin
            s_nxt.wrq = 1'b0;
        end
        // Read data is staged while waitrequest is high; a write lands only at the completing edge
        if (avs_read || avs_write) begin
            if (acc && avs_read) begin
                unique case (avs_address)
                    A_CTRL: s_nxt.rdata = {16'h0, s_r.iac};
                    A_TOP: s_nxt.rdata = {24'h0, s_r.dat[71:64]};
                    A_UP: s_nxt.rdata = {16'h0, s_r.dat[63:48]};
                    A_UMID: s_nxt.rdata = {16'h0, s_r.dat[47:32]};
                    A_LMID: s_nxt.rdata = {16'h0, s_r.dat[31:16]};
                    A_LOW: s_nxt.rdata = {16'h0, s_r.dat[15:0]};
                    default: s_nxt.rdata = RD_UNMAPPED;
                endcase
            end else if (wcmt) begin
                unique case (avs_address)
                    A_UP: s_nxt.dat[63:48] = mal_be16(s_r.dat[63:48], avs_writedata[15:0], avs_byteenable[1:0]);
                    A_UMID: s_nxt.dat[47:32] = mal_be16(s_r.dat[47:32], avs_writedata[15:0], avs_byteenable[1:0]);
                    A_LMID: s_nxt.dat[31:16] = mal_be16(s_r.dat[31:16], avs_writedata[15:0], avs_byteenable[1:0]);
                    A_LOW: s_nxt.dat[15:0] = mal_be16(s_r.dat[15:0], avs_writedata[15:0], avs_byteenable[1:0]);
                    A_CTRL: begin
                        iw = mal_be16(s_r.iac, avs_writedata[15:0], avs_byteenable[1:0]);
                        ix = iw[9:0];
                        dx = ix - DROP_BASE;
                        s_nxt.iac = iw;
                        // a new command cancels any pending learned read
                        s_nxt.hr_pend = 1'b0;
                        if (iw[IA_RD]) begin
                            unique case (iw[11:10])
                                SEL_STA: begin
                                    if (ix < 10'(NSTAT)) begin
                                        s_nxt.dat = {14'h0, s_r.stat[ix[2:0]]};
                                    end
                                end
                                SEL_DYN: begin
                                    s_nxt.hr_pend = 1'b1;
                                    s_nxt.hr_ix = ix;
                                    s_nxt.dat[DR_NRDY] = 1'b1;
                                end
                                SEL_MIB: begin
                                    if (ix >= DROP_BASE) begin
                                        if (dx < 10'h5 && dx != 10'h2) begin
                                            s_nxt.dat = {56'h0, s_r.drop[dx[2:0]]};
                                        end
                                    end else if (ix[9:6] == 4'h0 && {1'b0, ix[4:0]} < 6'(MIB_N)) begin
                                        pp_rd = 1'b1;
                                        pp_j = int'(ix[5]) * MIB_N + int'(ix[4:0]);
                                        s_nxt.dat = {40'h0, s_r.mib[pp_j][MIB_OVF], 1'b1, s_r.mib[pp_j][29:0]};
                                        s_nxt.mib[pp_j] = '0;
                                    end
                                end
                                default: ;
                            endcase
                        end else if (iw[11:10] == SEL_STA && ix < 10'(NSTAT)) begin
                            s_nxt.stat[ix[2:0]] = s_r.dat[57:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
        // ======================================================
        // Counters; applied last so an event in a clearing read survives
        for (int j = 0; j < 2 * MIB_N; j++) begin
            if (mib_inc[j]) begin
                t = {1'b0, s_nxt.mib[j][29:0]} + 31'h1;
                s_nxt.mib[j] = {s_nxt.mib[j][MIB_OVF] | t[30], t[29:0]};
            end
        end
        // Drop counters wrap silently; software tracks overflow
        for (int j = 0; j < 4; j++) begin
            if (drop_inc[j]) begin
                s_nxt.drop[j < 2 ? j : j + 1] = s_r.drop[j < 2 ? j : j + 1] + 16'h1;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.wrq <= WRQ_RST;
            s_r.st <= S_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Learned table storage; validity lives in s_r.dv so no memory reset is needed
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            dmem[mem_wa] <= mem_wd;
        end
        rd_q <= dmem[s_nxt.addr];
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.wrq;
    assign da_done = s_r.da_done;
    assign da_hit = s_r.da_hit;
    assign da_static = s_r.da_stat;
    assign da_fwd = s_r.da_fwd;
    assign da_override = s_r.da_ovr;
    assign sa_done = s_r.sa_done;
    assign sa_hit = s_r.sa_hit;
    assign sa_moved = s_r.sa_mov;

    // ==========================================================
    // Checks
    mib_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        pp_rd && !mib_inc[pp_j] |=> s_r.mib[$past(pp_j)] == 31'h0)
        else $error("counter not cleared by read");
    drop_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        drop_inc == 4'h0 |=> $stable(s_r.drop))
        else $error("drop counter changed without event");
    da_turn_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.st == S_IDLE && !s_r.hr_pend && da_req && !da_done |=> s_r.st == S_DA ##1 da_done)
        else $error("destination lookup not answered in two cycles");
    sa_learn_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.st == S_SA |-> mem_we && mem_wa == s_r.addr ##1 sa_done && !da_done)
        else $error("source lookup did not learn");
    static_win_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.st == S_DA && s_r.st_hit |=> da_static && da_hit && da_override == $past(s_r.st_ovr))
        else $error("static result not preferred");
    age_static_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_r.st == S_AG && !wcmt |=> $stable(s_r.stat))
        else $error("aging touched static table");
    not_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
        acc && avs_read && avs_address == A_TOP && s_r.hr_pend |=> avs_readdata[7] && !avs_waitrequest)
        else $error("pending learned read shown ready");
    count_empty_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s_r.cnt == 11'h0) == (s_r.dv == '0))
        else $error("entry count disagrees with validity");
endmodule : mal_lookup

// >>> hdl/mal_pkg.sv
// MAC address lookup package: register map, entry layouts, states.
// Assumes a word-addressed Avalon-MM slave port and one core clock.
package mal_pkg;
    // ==========================================================
    // Sizes
    localparam int NSTAT = 8;
    localparam int NDYN = 1024;
    // ==========================================================
    // Register word indices (byte address = 4 * index)
    localparam logic [2:0] A_CTRL = 3'h0;
    localparam logic [2:0] A_TOP = 3'h1;
    localparam logic [2:0] A_UP = 3'h2;
    localparam logic [2:0] A_UMID = 3'h3;
    localparam logic [2:0] A_LMID = 3'h4;
    localparam logic [2:0] A_LOW = 3'h5;
    localparam logic [31:0] RD_UNMAPPED = 32'h0;
    // ==========================================================
    // Indirect control word
    localparam int IA_RD = 12;
    localparam logic [1:0] SEL_STA = 2'h0;
    localparam logic [1:0] SEL_DYN = 2'h2;
    localparam logic [1:0] SEL_MIB = 2'h3;
    // ==========================================================
    // Static entry fields
    localparam int SF_USEGRP = 53;
    localparam int SF_OVR = 52;
    localparam int SF_VAL = 51;
    localparam int SF_FWD_LO = 48;
    localparam int GRP_HI = 57;
    localparam int GRP_LO = 54;
    // ==========================================================
    // Dynamic entry and read result fields
    localparam int DR_NRDY = 71;
    localparam int DR_EMPTY = 66;
    localparam int DR_CNT_LO = 56;
    localparam int DF_TS_LO = 54;
    localparam int DF_PORT_LO = 52;
    localparam int DF_GRP_LO = 48;
    localparam logic [1:0] TS_FRESH = 2'h3;
    // ==========================================================
    // Counters and waitrequest reset value
    localparam logic [9:0] DROP_BASE = 10'h100;
    localparam int MIB_OVF = 30;
    localparam logic WRQ_RST = 1'h1;
    // ==========================================================
    // Sequencer states
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_DA = 5'h02,
        S_SA = 5'h04,
        S_HR = 5'h08,
        S_AG = 5'h10
    } mal_st_t;
endpackage : mal_pkg

// >>> tb/test_mal_lookup.sv
// Testbench for mal_lookup: register bus, lookups, learning, aging and counters.
// Assumes the register map of mal_pkg; every wait on the block is bounded.
`timescale 1ns/1ps
module test_mal_lookup import mal_pkg::*; ();
    // ==========================================================
    // Signals
    logic ref_clk;
    logic rst;
    logic [2:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic vlan_en;
    logic da_req;
    logic [47:0] da_mac;
    logic [3:0] da_grp;
    logic [1:0] da_port;
    logic da_done;
    logic da_hit;
    logic da_static;
    logic [2:0] da_fwd;
    logic da_override;
    logic sa_req;
    logic [47:0] sa_mac;
    logic [3:0] sa_grp;
    logic [1:0] sa_port;
    logic sa_done;
    logic sa_hit;
    logic sa_moved;
    logic age_tick;
    logic [63:0] mib_inc;
    logic [3:0] drop_inc;
    int errors;
    int checks;
    logic [31:0] rd;
    // One address for every lookup: it hashes to learned index 5, or to 3 with vlan_en and group 6
    localparam logic [47:0] MAC = 48'h0000_0000_0005;

    mal_lookup #(.MIB_N(32)) i_mal_lookup (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vlan_en(vlan_en),
        .da_req(da_req), .da_mac(da_mac), .da_grp(da_grp), .da_port(da_port), .da_done(da_done),
        .da_hit(da_hit), .da_static(da_static), .da_fwd(da_fwd), .da_override(da_override),
        .sa_req(sa_req), .sa_mac(sa_mac), .sa_grp(sa_grp), .sa_port(sa_port), .sa_done(sa_done),
        .sa_hit(sa_hit), .sa_moved(sa_moved), .age_tick(age_tick), .mib_inc(mib_inc),
        .drop_inc(drop_inc)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Shared tasks
    task report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low; read data taken at that edge
    task bus(input logic w, input logic [2:0] a, input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_read <= ~w;
        avs_write <= w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            report_and_stop();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rdc(input logic [2:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk({16'h0000, rd[15:0]}, {16'h0000, exp});
    endtask : rdc

    // Polls the top word until the not-ready flag clears
    task dyn_read(input logic [15:0] idx);
        int n;
        bus(1'b1, A_CTRL, 16'h1800 | idx);
        n = 0;
        do begin
            bus(1'b0, A_TOP, 16'h0000);
            n++;
        end while (rd[7] !== 1'b0 && n < 20);
        if (rd[7] !== 1'b0) begin
            errors++;
            report_and_stop();
        end
    endtask : dyn_read

    task sta_write(input logic [15:0] hi, input logic [15:0] lo);
        bus(1'b1, A_UP, hi);
        bus(1'b1, A_UMID, 16'h0000);
        bus(1'b1, A_LMID, 16'h0000);
        bus(1'b1, A_LOW, lo);
        bus(1'b1, A_CTRL, 16'h0007);
    endtask : sta_write

    // Lookup result packed as hit, static, override, forwarding bitmap
    task da(input logic [3:0] grp, input logic [5:0] exp);
        int n;
        @(posedge ref_clk);
        da_mac <= MAC;
        da_grp <= grp;
        da_port <= 2'h0;
        da_req <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (da_done !== 1'b1 && n < 20);
        if (da_done !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        da_req <= 1'b0;
        chk({26'h0, da_hit, da_static, da_override, da_fwd}, {26'h0, exp});
    endtask : da

    task sa(input logic [1:0] port, input logic [1:0] exp);
        int n;
        @(posedge ref_clk);
        sa_mac <= MAC;
        sa_grp <= 4'h0;
        sa_port <= port;
        sa_req <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (sa_done !== 1'b1 && n < 20);
        if (sa_done !== 1'b1) begin
            errors++;
            report_and_stop();
        end
        sa_req <= 1'b0;
        chk({30'h0, sa_hit, sa_moved}, {30'h0, exp});
    endtask : sa

    // Three increments on port 0 counter 0x0E and one drop, then clearing and keeping reads
    task count_check;
        @(posedge ref_clk);
        mib_inc <= 64'h4000;
        drop_inc <= 4'h1;
        @(posedge ref_clk);
        drop_inc <= 4'h0;
        repeat (2) @(posedge ref_clk);
        mib_inc <= 64'h0;
        bus(1'b1, A_CTRL, 16'h1C0E);
        rdc(A_LMID, 16'h4000);
        rdc(A_LOW, 16'h0003);
        bus(1'b1, A_CTRL, 16'h1C0E);
        rdc(A_LOW, 16'h0000);
        bus(1'b1, A_CTRL, 16'h1D00);
        rdc(A_LOW, 16'h0001);
        bus(1'b1, A_CTRL, 16'h1D00);
        rdc(A_LOW, 16'h0001);
    endtask : count_check

    // A sweep takes two cycles per entry; four sweeps remove a fresh entry, the fifth is spare
    task age_check;
        repeat (5) begin
            @(posedge ref_clk);
            age_tick <= 1'b1;
            @(posedge ref_clk);
            age_tick <= 1'b0;
            repeat (2100) @(posedge ref_clk);
        end
        dyn_read(16'h0005);
        chk({24'h0, rd[7:0]}, 32'h04);
        bus(1'b1, A_CTRL, 16'h1007);
        rdc(A_UP, 16'h0177);
    endtask : age_check

    // ==========================================================
    // Main sequence
    initial begin
        errors = 0;
        checks = 0;
        rst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {vlan_en, da_req, da_mac, da_grp, da_port, sa_req, sa_mac, sa_grp, sa_port} = '0;
        {age_tick, mib_inc, drop_inc} = '0;
        avs_byteenable = 4'hF;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        dyn_read(16'h0000);
        chk({24'h0, rd[7:0]}, 32'h04);
        bus(1'b1, A_CTRL, 16'h1007);
        rdc(A_UP, 16'h0000);
        rdc(A_LOW, 16'h0000);
        rdc(3'h6, 16'h0000);
        sa(2'h1, 2'b00);
        sa(2'h1, 2'b10);
        dyn_read(16'h0005);
        chk({24'h0, rd[7:0]}, 32'h00);
        rdc(A_UP, 16'h00D0);
        rdc(A_LOW, 16'h0005);
        da(4'h0, 6'b100010);
        // Valid, group-keyed, override, broadcast, group 5
        sta_write(16'h017F, 16'h0005);
        bus(1'b1, A_CTRL, 16'h1007);
        rdc(A_UP, 16'h017F);
        rdc(A_LOW, 16'h0005);
        da(4'h5, 6'b111110);
        da(4'h6, 6'b100010);
        sta_write(16'h0177, 16'h0005);
        da(4'h5, 6'b100010);
        sa(2'h2, 2'b11);
        da(4'h6, 6'b100100);
        // Group joins the key: group 0 still finds the entry, group 6 hashes elsewhere and misses
        vlan_en <= 1'b1;
        da(4'h0, 6'b100100);
        da(4'h6, 6'b000000);
        vlan_en <= 1'b0;
        count_check();
        age_check();
        report_and_stop();
    end
endmodule : test_mal_lookup
